// file: design/l1_block_defines.svh
`ifndef L1_BLOCK_DEFINES_SVH
`define L1_BLOCK_DEFINES_SVH

// Geometry of one memory block: eight byte lanes, two per 16-bit column.
`define LANES 8
`define ROW_W 10
`define OFF_W 13
`define KEY_W 15
`define SRC_N 8

// Requester indices, lowest index wins a block conflict.
`define SRC_SLAVE1 3'h0
`define SRC_SLAVE2 3'h1
`define SRC_DATA 3'h2
`define SRC_PROG 3'h3
`define SRC_FETCH 3'h4
`define SRC_DFILL_DATA 3'h5
`define SRC_DFILL_PROG 3'h6
`define SRC_IFILL 3'h7

// Address space codes carried in the top address bits.
`define SPACE_LONG 2'h0
`define SPACE_NORMAL 2'h1
`define SPACE_SHORT 2'h2
`define SPACE_BYTE 2'h3

// Size modifier codes for byte space accesses.
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

// Byte lanes touched per access width.
`define LANES_BYTE 4'h1
`define LANES_SHORT 4'h2
`define LANES_NORMAL 4'h4
`define LANES_WIDE 4'h6
`define LANES_LONG 4'h8

// Extended precision data sits above an unused low byte.
`define X40_PAD 8'h00

`endif

// file: design/l1_block_pkg.sv
package l1_block_pkg;
`include "l1_block_defines.svh"

  typedef enum logic [1:0] {
    SPACE_LONG = `SPACE_LONG,
    SPACE_NORMAL = `SPACE_NORMAL,
    SPACE_SHORT = `SPACE_SHORT,
    SPACE_BYTE = `SPACE_BYTE
  } space_e;

  typedef enum logic [1:0] {
    SIZE_BYTE = `SIZE_BYTE,
    SIZE_HALF = `SIZE_HALF,
    SIZE_WORD = `SIZE_WORD
  } size_e;

  // One request from a bus or port into the block.
  typedef struct packed {
    logic valid;
    logic write;
    space_e space;
    size_e size;
    logic simd;
    logic [`OFF_W-1:0] offset;
    logic [63:0] wdata;
  } req_s;

  // Placement of one access across the byte lanes.
  typedef struct packed {
    logic [`ROW_W-1:0] row;
    logic [2:0] sl;
    logic [3:0] n;
  } map_s;

  // All registered state of the interface except the two reset flip-flops.
  typedef struct packed {
    logic p1_valid;
    logic [2:0] p1_src;
    logic [2:0] p1_sl;
    logic [3:0] p1_n;
    logic p1_x40;
    logic p1_fill;
    logic p1_hit;
    logic [`SRC_N-1:0] resp_valid;
    logic [63:0] resp_data;
    logic instr_valid;
    logic [47:0] instr_data;
    logic cc_valid;
    logic [`KEY_W-1:0] cc_key;
    logic [47:0] cc_data;
    logic victim;
  } state_s;

endpackage : l1_block_pkg

// file: design/column_store.sv
`timescale 1ns/10ps
// Eight byte-lane memories, each with its own row address so that rotated words can straddle two rows.
module column_store #(
  parameter int LANES = 8,
  parameter int ROW_W = 10
) (
  input wire logic clk,
  input wire logic [LANES-1:0][ROW_W-1:0] row_addr,
  input wire logic [LANES-1:0] we,
  input wire logic [LANES*8-1:0] wdata,
  output logic [LANES*8-1:0] rdata
);

  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_lane
      logic [7:0] mem [2**ROW_W];
      // Each lane writes its byte when enabled and always returns the addressed byte, as it was before any write, one cycle later.
      always_ff @(posedge clk) begin
        if (we[l]) begin
          mem[row_addr[l]] <= wdata[l*8 +: 8];
        end
        rdata[l*8 +: 8] <= mem[row_addr[l]];
      end
    end
  endgenerate

endmodule : column_store

// file: design/l1_block_if.sv
`timescale 1ns/10ps
module l1_block_if
  import l1_block_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic forty_bit_enable_block_zero,
  input wire logic forty_bit_enable_block_three,
  input wire req_s [`SRC_N-1:0] req,
  output logic [`SRC_N-1:0] grant,
  output logic [`SRC_N-1:0] stall,
  output logic [`SRC_N-1:0] resp_valid,
  output logic [63:0] resp_data,
  output logic instr_hit_valid,
  output logic [47:0] instr_hit_data
);

  // Rotates a 64-bit word left by whole bytes.
  function automatic logic [63:0] rotl64(input logic [63:0] d, input logic [2:0] s);
    logic [127:0] t;
    t = {d, d} << {s, 3'h0};
    return t[127:64];
  endfunction : rotl64

  // Rotates a 64-bit word right by whole bytes.
  function automatic logic [63:0] rotr64(input logic [63:0] d, input logic [2:0] s);
    logic [127:0] t;
    t = {d, d} >> {s, 3'h0};
    return t[63:0];
  endfunction : rotr64

  // Gives n low ones over the eight lanes.
  function automatic logic [7:0] mask8(input logic [3:0] n);
    logic [15:0] t;
    t = (16'h0001 << n) - 16'h0001;
    return t[7:0];
  endfunction : mask8

  // Maps a request onto a starting lane, a lane count and a base row.
  function automatic map_s lane_map(input req_s r, input logic wide);
    map_s m;
    logic [`OFF_W+1:0] lin;
    m = '0;
    lin = '0;
    if (wide) begin
      lin = {2'h0, r.offset} + {1'h0, r.offset, 1'h0};
      m.row = lin[`ROW_W+1:2];
      m.sl = {lin[1:0], 1'h0};
      m.n = `LANES_WIDE;
    end else begin
      case (r.space)
        SPACE_LONG: begin
          m.row = r.offset[`ROW_W-1:0];
          m.sl = 3'h0;
          m.n = `LANES_LONG;
        end
        SPACE_NORMAL: begin
          m.row = r.offset[`ROW_W:1];
          m.sl = {r.offset[0], 2'h0};
          m.n = r.simd ? `LANES_LONG : `LANES_NORMAL;
        end
        SPACE_SHORT: begin
          m.row = r.offset[`ROW_W+1:2];
          m.sl = {r.offset[1:0], 1'h0};
          m.n = r.simd ? `LANES_NORMAL : `LANES_SHORT;
        end
        default: begin
          m.row = r.offset[`ROW_W+2:3];
          m.sl = r.offset[2:0];
          case (r.size)
            SIZE_HALF: m.n = `LANES_SHORT;
            SIZE_WORD: m.n = `LANES_NORMAL;
            default: m.n = `LANES_BYTE;
          endcase
          if (r.simd) begin
            m.n = m.n << 1;
          end
        end
      endcase
    end
    return m;
  endfunction : lane_map

  logic [1:0] rst_pipe;
  logic rst_n;
  state_s s, s_next;
  logic [`SRC_N-1:0] ram_req, ram_grant;
  logic [2:0] win;
  logic found, conflict, cc_hit, cc_serve, wide, f40, x40;
  req_s sel;
  map_s m;
  logic [7:0] lane_en, lane_we;
  logic [`LANES-1:0][`ROW_W-1:0] lane_row;
  logic [63:0] ram_wdata, ram_rdata, rd_rot, rd_mask;
  logic [15:0] lane_dbl;

  // Reset is released through two flip-flops.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'h1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Each lane takes the base row, or the next row where a rotated word wraps.
  genvar l;
  generate
    for (l = 0; l < `LANES; l++) begin : g_row
      assign lane_row[l] = m.row + `ROW_W'(l < int'(m.sl));
    end
  endgenerate

  // All block, port and spaces share one set of lanes, so gap locations alias both word types.
  column_store #(.LANES(`LANES), .ROW_W(`ROW_W)) u_store (
    .clk(clk),
    .row_addr(lane_row),
    .we(lane_we),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  // Arbitration, lane mapping, conflict cache and the answer pipeline.
  always_comb begin
    s_next = s;
    conflict = req[`SRC_PROG].valid && req[`SRC_FETCH].valid;
    cc_hit = s.cc_valid && ({req[`SRC_FETCH].space, req[`SRC_FETCH].offset} == s.cc_key);
    cc_serve = conflict && cc_hit;
    ram_req = '0;
    for (int i = 0; i < `SRC_N; i++) begin
      ram_req[i] = req[i].valid;
    end
    if (cc_serve) begin
      ram_req[`SRC_FETCH] = 1'h0;
    end
    ram_grant = '0;
    win = 3'h0;
    found = 1'h0;
    for (int i = 0; i < `SRC_N; i++) begin
      if (ram_req[i] && !found) begin
        ram_grant[i] = 1'h1;
        win = 3'(i);
        found = 1'h1;
      end
    end
    grant = ram_grant;
    grant[`SRC_FETCH] = ram_grant[`SRC_FETCH] | cc_serve;
    stall = ram_req & ~ram_grant;
    sel = req[win];
    wide = (win == `SRC_FETCH) || (win == `SRC_IFILL);
    f40 = forty_bit_enable_block_zero && forty_bit_enable_block_three;
    x40 = !wide && f40 && (sel.space == SPACE_NORMAL) && !sel.simd;
    m = lane_map(sel, wide || x40);
    lane_en = found ? mask8(m.n) : 8'h00;
    // Doubling the mask and keeping the upper half rotates it without losing wrapped lanes.
    lane_dbl = {lane_en, lane_en} << m.sl;
    lane_en = lane_dbl[15:8];
    lane_we = lane_en & {8{sel.write && found}};
    ram_wdata = rotl64(x40 ? {16'h0000, sel.wdata[39:0], `X40_PAD} : sel.wdata, m.sl);
    // Stage one remembers how to unpack the lanes that come back.
    s_next.p1_valid = found;
    s_next.p1_src = win;
    s_next.p1_sl = m.sl;
    s_next.p1_n = m.n;
    s_next.p1_x40 = x40;
    s_next.p1_fill = found && (win == `SRC_FETCH) && s.victim;
    s_next.p1_hit = cc_serve;
    // The fetch that lost to program-side data is marked for caching, the set winning over the clear.
    if (found && (win == `SRC_FETCH)) begin
      s_next.victim = 1'h0;
    end
    if (conflict && !cc_hit) begin
      s_next.victim = 1'h1;
    end
    if (s_next.p1_fill) begin
      s_next.cc_valid = 1'h0;
      s_next.cc_key = {sel.space, sel.offset};
    end
    // Stage two turns lanes back into right-aligned data.
    rd_rot = rotr64(ram_rdata, s.p1_sl);
    rd_mask = '0;
    for (int b = 0; b < `LANES; b++) begin
      if (b < int'(s.p1_n)) begin
        rd_mask[b*8 +: 8] = 8'hFF;
      end
    end
    s_next.resp_valid = s.p1_valid ? (`SRC_N'(1) << s.p1_src) : '0;
    s_next.resp_data = s.p1_x40 ? {24'h000000, rd_rot[47:8]} : (rd_rot & rd_mask);
    if (s.p1_fill) begin
      s_next.cc_valid = 1'h1;
      s_next.cc_data = rd_rot[47:0];
    end
    s_next.instr_valid = s.p1_hit;
    s_next.instr_data = s.cc_data;
  end

  // All state registers except the reset flip-flops in one place.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= s_next;
    end
  end

  assign resp_valid = s.resp_valid;
  assign resp_data = s.resp_data;
  assign instr_hit_valid = s.instr_valid;
  assign instr_hit_data = s.instr_data;

  property p_one_grant;
    @(posedge clk) disable iff (!rst_n) $onehot0(ram_grant);
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("more than one block grant");

  property p_slave_first;
    @(posedge clk) disable iff (!rst_n) req[`SRC_SLAVE1].valid |-> grant[`SRC_SLAVE1] && !grant[`SRC_DATA];
  endproperty
  a_slave_first: assert property (p_slave_first) else $error("slave port did not win");

  property p_slave_order;
    @(posedge clk) disable iff (!rst_n)
      req[`SRC_SLAVE1].valid && req[`SRC_SLAVE2].valid |-> grant[`SRC_SLAVE1] && stall[`SRC_SLAVE2];
  endproperty
  a_slave_order: assert property (p_slave_order) else $error("slave port 2 beat port 1");

  property p_dual_extra;
    @(posedge clk) disable iff (!rst_n)
      req[`SRC_DATA].valid && req[`SRC_PROG].valid && !req[`SRC_SLAVE1].valid && !req[`SRC_SLAVE2].valid
      |-> stall[`SRC_PROG] ##2 resp_valid[`SRC_DATA];
  endproperty
  a_dual_extra: assert property (p_dual_extra) else $error("dual access to one block took no extra cycle");

  property p_answer_latency;
    @(posedge clk) disable iff (!rst_n) ram_grant[`SRC_DATA] |-> ##2 resp_valid[`SRC_DATA];
  endproperty
  a_answer_latency: assert property (p_answer_latency) else $error("granted access not answered");

  property p_cache_hit;
    @(posedge clk) disable iff (!rst_n)
      cc_serve |-> grant[`SRC_FETCH] && !ram_grant[`SRC_FETCH]
      ##2 instr_hit_valid && instr_hit_data == $past(s.cc_data, 1);
  endproperty
  a_cache_hit: assert property (p_cache_hit) else $error("conflict cache hit not served");

  property p_cache_miss;
    @(posedge clk) disable iff (!rst_n)
      conflict && !cc_hit && grant[`SRC_PROG] |-> stall[`SRC_FETCH] ##1 s.victim;
  endproperty
  a_cache_miss: assert property (p_cache_miss) else $error("conflict cache miss not marked for fill");

  property p_fetch_width;
    @(posedge clk) disable iff (!rst_n) ram_grant[`SRC_FETCH] |-> $countones(lane_en) == 6;
  endproperty
  a_fetch_width: assert property (p_fetch_width) else $error("fetch did not touch three columns");

  property p_long_fixed;
    @(posedge clk) disable iff (!rst_n)
      found && !wide && sel.space == SPACE_LONG |-> lane_en == 8'hFF && lane_row[0] == lane_row[7];
  endproperty
  a_long_fixed: assert property (p_long_fixed) else $error("long access was rotated");

  property p_wide_rows;
    @(posedge clk) disable iff (!rst_n) found && wide && m.sl != 3'h0 |-> lane_row[0] == lane_row[7] + 10'h001;
  endproperty
  a_wide_rows: assert property (p_wide_rows) else $error("wrapped lanes not on next row");

  property p_byte_lane;
    @(posedge clk) disable iff (!rst_n)
      found && !wide && sel.space == SPACE_BYTE && sel.size == SIZE_BYTE && !sel.simd |-> $countones(lane_en) == 1;
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte access did not touch one lane");

  property p_x40_lanes;
    @(posedge clk) disable iff (!rst_n) found && x40 |-> $countones(lane_en) == `LANES_WIDE;
  endproperty
  a_x40_lanes: assert property (p_x40_lanes) else $error("extended word did not touch three columns");

  property p_fill_cache;
    @(posedge clk) disable iff (!rst_n) s.p1_fill |=> s.cc_valid;
  endproperty
  a_fill_cache: assert property (p_fill_cache) else $error("missed fetch was not cached");

  property p_one_answer;
    @(posedge clk) disable iff (!rst_n) $onehot0(resp_valid);
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("more than one answer in a cycle");

endmodule : l1_block_if

// file: tb/requester_model.sv
`timescale 1ns/10ps
// Stands in for one bus or port: takes a command, holds it while stalled, keeps the last answer.
module requester_model
  import l1_block_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire req_s cmd,
  input wire logic go,
  input wire logic grant_bit,
  input wire logic resp_bit,
  input wire logic [63:0] resp_data,
  output req_s req,
  output logic [63:0] rdata,
  output logic [7:0] resp_count
);
  // A stalled request stays unchanged; once taken, the released fields are scrambled.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req <= '0;
      rdata <= '0;
      resp_count <= 8'h00;
    end else begin
      if (go) begin
        req <= cmd;
      end else if (req.valid && grant_bit) begin
        req.valid <= 1'b0;
        req.wdata <= ~req.wdata;
        req.offset <= ~req.offset;
      end
      if (resp_bit) begin
        rdata <= resp_data;
        resp_count <= resp_count + 8'h01;
      end
    end
  end
endmodule : requester_model

// file: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import l1_block_pkg::*;
  typedef struct packed {
    logic [2:0] src;
    logic wr;
    logic x40;
    space_e sp;
    size_e sz;
    logic [12:0] off;
    logic [63:0] d;
  } row_s;
  logic clk, arst_n, en0, en1, instr_hit_valid;
  logic [7:0] go, grant, stall, resp_valid;
  logic [63:0] resp_data;
  logic [47:0] instr_hit_data, hit_data;
  req_s cmd [7:0];
  req_s req [7:0];
  req_s [7:0] req_bus;
  logic [63:0] rdata [7:0];
  logic [7:0] rcnt [7:0];
  int failures, check_count, hits;
  int gq[$];
  // Writes carry data in d, reads carry the expected value in d.
  row_s rows [17] = '{
    '{3'h2, 1'b1, 1'b0, SPACE_LONG, SIZE_BYTE, 13'h002, 64'h1122334455667788},
    '{3'h2, 1'b1, 1'b0, SPACE_NORMAL, SIZE_BYTE, 13'h005, 64'hA1B2C3D4},
    '{3'h0, 1'b0, 1'b0, SPACE_SHORT, SIZE_BYTE, 13'h00A, 64'hC3D4},
    '{3'h3, 1'b0, 1'b0, SPACE_SHORT, SIZE_BYTE, 13'h00B, 64'hA1B2},
    '{3'h1, 1'b0, 1'b0, SPACE_BYTE, SIZE_BYTE, 13'h014, 64'hD4},
    '{3'h5, 1'b0, 1'b0, SPACE_BYTE, SIZE_HALF, 13'h015, 64'hB2C3},
    '{3'h6, 1'b0, 1'b0, SPACE_LONG, SIZE_BYTE, 13'h002, 64'hA1B2C3D455667788},
    '{3'h1, 1'b1, 1'b0, SPACE_BYTE, SIZE_WORD, 13'h019, 64'hDEADBEEF},
    '{3'h2, 1'b0, 1'b0, SPACE_SHORT, SIZE_BYTE, 13'h00D, 64'hADBE},
    '{3'h2, 1'b1, 1'b1, SPACE_NORMAL, SIZE_BYTE, 13'h001, 64'h123456789A},
    '{3'h0, 1'b0, 1'b1, SPACE_SHORT, SIZE_BYTE, 13'h003, 64'h9A00},
    '{3'h0, 1'b0, 1'b1, SPACE_SHORT, SIZE_BYTE, 13'h004, 64'h5678},
    '{3'h3, 1'b0, 1'b1, SPACE_NORMAL, SIZE_BYTE, 13'h001, 64'h123456789A},
    // A 32-bit region starts one past three halves of the two 48-bit words, a 48-bit word follows on a row.
    '{3'h2, 1'b1, 1'b0, SPACE_NORMAL, SIZE_BYTE, 13'h004, 64'h0BADF00D},
    '{3'h1, 1'b1, 1'b1, SPACE_NORMAL, SIZE_BYTE, 13'h004, 64'hFEEDC0FFEE},
    '{3'h3, 1'b0, 1'b1, SPACE_NORMAL, SIZE_BYTE, 13'h001, 64'h123456789A},
    '{3'h0, 1'b0, 1'b0, SPACE_NORMAL, SIZE_BYTE, 13'h004, 64'h0BADF00D}
  };

  l1_block_if u_l1_block_if (.clk(clk), .arst_n(arst_n), .forty_bit_enable_block_zero(en0),
    .forty_bit_enable_block_three(en1), .req(req_bus), .grant(grant), .stall(stall), .resp_valid(resp_valid),
    .resp_data(resp_data), .instr_hit_valid(instr_hit_valid), .instr_hit_data(instr_hit_data));

  for (genvar i = 0; i < 8; i++) begin : g_req
    requester_model u_requester_model (.clk(clk), .arst_n(arst_n), .cmd(cmd[i]), .go(go[i]),
      .grant_bit(grant[i]), .resp_bit(resp_valid[i]), .resp_data(resp_data), .req(req[i]),
      .rdata(rdata[i]), .resp_count(rcnt[i]));
  end

  // Gathers the eight requester outputs onto the block's packed request port.
  always_comb begin
    for (int i = 0; i < 8; i++) req_bus[i] = req[i];
  end

  // Clock at 20 MHz.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic cmp(input string name, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic conclude();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  function automatic logic [63:0] mask(input row_s r);
    if (r.sp == SPACE_LONG) return '1;
    if (r.sp == SPACE_SHORT || (r.sp == SPACE_BYTE && r.sz == SIZE_HALF)) return 64'hFFFF;
    if (r.sp == SPACE_BYTE && r.sz == SIZE_BYTE) return 64'hFF;
    if (r.sp == SPACE_NORMAL && r.x40) return 64'hFF_FFFF_FFFF;
    return 64'hFFFF_FFFF;
  endfunction : mask

  // Loads one command into its requester; call just after a rising edge.
  task automatic issue(input row_s r);
    cmd[r.src] <= '{valid: 1'b1, write: r.wr, space: r.sp, size: r.sz, simd: 1'b0, offset: r.off, wdata: r.d};
    go[r.src] <= 1'b1;
  endtask : issue

  task automatic wait_resp(input int s, input logic [7:0] c);
    int n;
    n = 0;
    while (rcnt[s] === c && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) begin
      failures++;
      $display("[ERR] resp_valid expected 1 seen 0");
    end
  endtask : wait_resp

  task automatic run(input row_s r);
    logic [7:0] c;
    c = rcnt[r.src];
    @(posedge clk);
    issue(r);
    en0 <= r.x40;
    en1 <= r.x40;
    @(posedge clk);
    go <= 8'h00;
    wait_resp(r.src, c);
    if (!r.wr) cmp("resp_data", r.d, rdata[r.src] & mask(r));
  endtask : run

  // Program-side data and a fetch of offset 12 presented in the same cycle.
  task automatic conflict();
    @(posedge clk);
    issue('{3'h3, 1'b0, 1'b0, SPACE_SHORT, SIZE_BYTE, 13'h000, 64'h0});
    issue('{3'h4, 1'b0, 1'b0, SPACE_NORMAL, SIZE_BYTE, 13'h00C, 64'h0});
    @(posedge clk);
    go <= 8'h00;
  endtask : conflict

  // Records grant order, the conflict cache answers, and checks stall against grant.
  always @(posedge clk) begin
    if (arst_n) begin
      for (int i = 0; i < 8; i++) begin
        if (grant[i]) gq.push_back(i);
        if (req[i].valid) cmp("stall", 64'(!grant[i]), 64'(stall[i]));
      end
      if (instr_hit_valid) begin
        hits++;
        hit_data = instr_hit_data;
      end
    end
  end

  // Watchdog at 8000 cycles, well beyond the fewer than two hundred cycles the tests need.
  initial begin
    #400000;
    failures++;
    conclude();
  end

  initial begin
    logic [7:0] c;
    int h;
    arst_n = 1'b0;
    en0 = 1'b0;
    en1 = 1'b0;
    go = 8'h00;
    for (int i = 0; i < 8; i++) cmd[i] = '0;
    repeat (20) @(posedge clk);
    cmp("resp_valid", 64'h0, 64'(resp_valid));
    cmp("instr_hit_valid", 64'h0, 64'(instr_hit_valid));
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    $display("test reset done");
    foreach (rows[k]) run(rows[k]);
    $display("test table done");
    // All eight requesters collide on the block at once.
    gq.delete();
    c = rcnt[7];
    @(posedge clk);
    for (int i = 0; i < 8; i++) issue('{3'(i), 1'b0, 1'b0, SPACE_SHORT, SIZE_BYTE, 13'(i), 64'h0});
    @(posedge clk);
    go <= 8'h00;
    wait_resp(7, c);
    cmp("grant_count", 64'd8, 64'(gq.size()));
    for (int i = 0; i < 8; i++) cmp("grant_order", 64'(i), 64'(gq[i]));
    $display("test priority done");
    run('{3'h0, 1'b1, 1'b0, SPACE_LONG, SIZE_BYTE, 13'h009, 64'h0000CAFEF00DBEEF});
    gq.delete();
    h = hits;
    c = rcnt[4];
    conflict();
    wait_resp(4, c);
    cmp("fetch_data", 64'hCAFEF00DBEEF, rdata[4] & 64'hFFFF_FFFF_FFFF);
    cmp("grant_order", 64'd3, 64'(gq[0]));
    cmp("grant_order", 64'd4, 64'(gq[1]));
    cmp("hit_count", 64'(h), 64'(hits));
    conflict();
    repeat (4) @(posedge clk);
    cmp("hit_count", 64'(h + 1), 64'(hits));
    cmp("hit_data", 64'hCAFEF00DBEEF, 64'(hit_data));
    $display("test conflict cache done");
    // A reset in mid-run must forget the cached instruction, so the same conflict misses again.
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    cmp("resp_valid", 64'h0, 64'(resp_valid));
    cmp("instr_hit_valid", 64'h0, 64'(instr_hit_valid));
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    h = hits;
    c = rcnt[4];
    conflict();
    wait_resp(4, c);
    cmp("fetch_data", 64'hCAFEF00DBEEF, rdata[4] & 64'hFFFF_FFFF_FFFF);
    cmp("hit_count", 64'(h), 64'(hits));
    $display("test mid-run reset done");
    conclude();
  end
endmodule : testbench
